// ---- include/acl_pkg.sv ----
package acl_pkg;
  // Clock and time base
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int HOLD_MS = 2000;
  localparam int MSG_MS = 250;
  localparam int IDLE_S = 40;
  localparam int AGE_MIN = 10;
  localparam logic [10:0] HOLD_TK = 11'(HOLD_MS / TICK_MS);
  localparam logic [7:0] MSG_TK = 8'(MSG_MS / TICK_MS);
  localparam logic [15:0] IDLE_TK = 16'(IDLE_S * 1000 / TICK_MS);
  localparam logic [9:0] SEC_TK = 10'(1000 / TICK_MS);
  localparam logic [9:0] AGE_SEC = 10'(AGE_MIN * 60);

  // Sizes
  localparam int NKEY = 5;
  localparam int NCH = 16;
  localparam int NLIST = 25;
  localparam int ID_W = 17;
  localparam int VAL_W = 16;
  localparam int CODE_W = 14;
  localparam logic [4:0] LIST_LAST = 5'(NLIST - 1);
  localparam logic [1:0] CUR_LAST = 2'h3;

  // Key bit positions
  localparam int K_EXIT = 0;
  localparam int K_SEL = 1;
  localparam int K_EDIT = 2;
  localparam int K_DOWN = 3;
  localparam int K_UP = 4;

  // Register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CODE_IN = 8'h04;
  localparam logic [7:0] REG_CODE_SET = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CH_SEL = 8'h10;
  localparam logic [7:0] REG_CH_ID = 8'h14;

  // Field positions and reset values
  localparam int CTRL_DIGIT_BIT = 0;
  localparam int ST_LVL_BIT = 3;
  localparam int ST_EDIT_BIT = 4;
  localparam int CHID_VLD_BIT = 17;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [CODE_W-1:0] CODE_RST = 14'h0000;

  typedef enum logic [2:0] {
    ST_HOME, ST_CODE, ST_OK, ST_ERR, ST_SETUP, ST_LIST, ST_LINK, ST_SET
  } acl_state_t;

  typedef struct packed {
    logic up;
    logic down;
    logic edit;
    logic sel;
    logic exit;
  } acl_keys_t;

  typedef struct packed {
    logic valid;
    logic [ID_W-1:0] id;
    logic [VAL_W-1:0] value;
  } acl_tgm_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ch;
    logic [VAL_W-1:0] value;
  } acl_dlv_t;
endpackage

// ---- src/acl_core.sv ----
`timescale 1ns/1ps
// How it works
// - Long hold asks level; prompt if coded
// - Direct mode: up/down step whole code
// - Good code: OK message, then level
// - Bad code: error message, then home
// - Edit key starts at rightmost digit
// - Up/down change digit; edit moves left
// - Short select stops edit; hold submits
// - Setup code zero means no prompt
// - Deliver to first linked channel only
// - Unlinked IDs join list, 25 max
// - Drop entries unheard ten minutes
// - Linked IDs never shown in list
// - Open list frozen, newest first
// - Up/down pick channel; select opens list
// - Select picks; hold links, shows message
// - Exit hold or idle returns home
// - Both codes inactive after reset
// - Separate code per protected level
module acl_core
  import acl_pkg::*;
#(
  parameter int unsigned TICK_CYC = TICK_CYC_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front keys
  input wire acl_keys_t keys,
  // Telegram receiver
  input wire acl_tgm_t rx,
  output acl_dlv_t dlv,
  // Display
  output acl_state_t disp_state,
  output logic [15:0] disp_code,
  output logic [1:0] disp_cursor,
  output logic disp_cursor_flash,
  output logic [3:0] disp_ch,
  output logic [ID_W-1:0] disp_id,
  output logic disp_id_flash
);

  function automatic logic [3:0] dig_step(input logic [3:0] d,
                                          input logic up);
    if (up)
      dig_step = (d == 4'h9) ? 4'h0 : d + 4'h1;
    else
      dig_step = (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction

  function automatic logic [15:0] bcd_step(input logic [15:0] v,
                                           input logic up);
    logic [15:0] r;
    logic c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        r[i*4+:4] = dig_step(r[i*4+:4], up);
        c = up ? (r[i*4+:4] == 4'h0) : (r[i*4+:4] == 4'h9);
      end
    end
    bcd_step = r;
  endfunction

  function automatic logic [CODE_W-1:0] bcd2bin(input logic [15:0] v);
    bcd2bin = 14'(v[15:12]) * 14'd1000 + 14'(v[11:8]) * 14'd100 +
              14'(v[7:4]) * 14'd10 + 14'(v[3:0]);
  endfunction

  acl_state_t state_q;
  logic [NKEY-1:0] kmeta_q, kv, kprev_q;
  logic [NKEY-1:0] ev_press, ev_short, ev_long;
  logic [10:0] hold_q [NKEY];
  logic [15:0] tick_q, idle_q;
  logic [9:0] ms_q;
  logic [7:0] msg_q;
  logic tick, sec, msg_done, idle_to, any_key;
  logic digit_mode_q, lvl_q, editing_q, picked_q, seen_q;
  logic [CODE_W-1:0] code_in_q, code_set_q;
  logic [3:0] ch_sel_q, ch_q, home_ch_q;
  logic [15:0] digits_q;
  logic [1:0] cursor_q;
  logic [4:0] list_idx_q, pick_idx_q;
  logic link_vld_q [NCH];
  logic [ID_W-1:0] link_id_q [NCH];
  logic lst_vld_q [NLIST];
  logic [ID_W-1:0] lst_id_q [NLIST];
  logic [9:0] lst_age_q [NLIST];
  logic rx_hit, lst_hit, lst_free, frozen, link_we, code_ok;
  logic [3:0] hit_ch;
  logic [4:0] lst_k, hit_idx, free_idx;

  // Key synchroniser and timing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      kmeta_q <= '0;
      kv <= '0;
      kprev_q <= '0;
    end else begin
      kmeta_q <= keys;
      kv <= kmeta_q;
      kprev_q <= kv;
    end
  end

  for (genvar k = 0; k < NKEY; k++) begin : g_key
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
        hold_q[k] <= '0;
      else if (!kv[k])
        hold_q[k] <= '0;
      else if (tick && hold_q[k] != HOLD_TK)
        hold_q[k] <= hold_q[k] + 11'h001;
    end
    assign ev_long[k] = kv[k] && tick && hold_q[k] == HOLD_TK - 11'h001;
    assign ev_short[k] = kprev_q[k] && !kv[k] && hold_q[k] != HOLD_TK;
    assign ev_press[k] = kv[k] && !kprev_q[k];
  end

  assign tick = tick_q == 16'(TICK_CYC - 1);
  assign sec = tick && ms_q == SEC_TK - 10'h001;
  assign msg_done = tick && msg_q == MSG_TK - 8'h01;
  assign idle_to = tick && idle_q == IDLE_TK - 16'h0001;
  assign any_key = |ev_press;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_q <= '0;
      ms_q <= '0;
    end else begin
      tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
      if (sec)
        ms_q <= '0;
      else if (tick)
        ms_q <= ms_q + 10'h001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      idle_q <= '0;
    else if (any_key || state_q == ST_HOME)
      idle_q <= '0;
    else if (tick)
      idle_q <= idle_q + 16'h0001;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      msg_q <= '0;
    else if (state_q != ST_OK && state_q != ST_ERR && state_q != ST_LINK)
      msg_q <= '0;
    else if (tick)
      msg_q <= msg_q + 8'h01;
  end

  // Operator state machine
  assign code_ok = bcd2bin(digits_q) ==
                   (lvl_q ? code_set_q : code_in_q);
  assign link_we = state_q == ST_LIST && picked_q && ev_long[K_SEL];
  assign frozen = state_q == ST_LIST;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_HOME;
      lvl_q <= 1'b0;
      editing_q <= 1'b0;
      cursor_q <= '0;
      digits_q <= '0;
      ch_q <= '0;
      home_ch_q <= '0;
      list_idx_q <= '0;
      pick_idx_q <= '0;
      picked_q <= 1'b0;
      seen_q <= 1'b0;
    end else if (state_q != ST_HOME && (ev_long[K_EXIT] || idle_to)) begin
      state_q <= ST_HOME;
      editing_q <= 1'b0;
    end else begin
      case (state_q)
        ST_HOME: begin
          digits_q <= '0;
          cursor_q <= '0;
          editing_q <= 1'b0;
          ch_q <= home_ch_q;
          if (ev_press[K_UP])
            home_ch_q <= home_ch_q + 4'h1;
          else if (ev_press[K_DOWN])
            home_ch_q <= home_ch_q - 4'h1;
          if (ev_long[K_EDIT]) begin
            lvl_q <= 1'b0;
            state_q <= (code_in_q == CODE_RST) ? ST_SETUP : ST_CODE;
          end else if (ev_long[K_SEL]) begin
            lvl_q <= 1'b1;
            state_q <= (code_set_q == CODE_RST) ? ST_SET : ST_CODE;
          end
        end
        ST_CODE: begin
          if (ev_long[K_SEL]) begin
            editing_q <= 1'b0;
            state_q <= code_ok ? ST_OK : ST_ERR;
          end else if (ev_short[K_SEL]) begin
            editing_q <= 1'b0;
          end else if (digit_mode_q && ev_short[K_EDIT]) begin
            if (!editing_q) begin
              editing_q <= 1'b1;
              cursor_q <= '0;
            end else if (cursor_q != CUR_LAST) begin
              cursor_q <= cursor_q + 2'h1;
            end else begin
              editing_q <= 1'b0;
            end
          end else if (ev_press[K_UP] || ev_press[K_DOWN]) begin
            if (!digit_mode_q)
              digits_q <= bcd_step(digits_q, ev_press[K_UP]);
            else if (editing_q)
              digits_q[cursor_q*4+:4] <=
                dig_step(digits_q[cursor_q*4+:4], ev_press[K_UP]);
          end
        end
        ST_OK: begin
          if (msg_done)
            state_q <= lvl_q ? ST_SET : ST_SETUP;
        end
        ST_ERR: begin
          if (msg_done)
            state_q <= ST_HOME;
        end
        ST_SETUP: begin
          if (ev_press[K_UP])
            ch_q <= ch_q + 4'h1;
          else if (ev_press[K_DOWN])
            ch_q <= ch_q - 4'h1;
          else if (ev_short[K_SEL]) begin
            state_q <= ST_LIST;
            list_idx_q <= '0;
            picked_q <= 1'b0;
            seen_q <= 1'b0;
          end
        end
        ST_LIST: begin
          if (link_we) begin
            state_q <= ST_LINK;
          end else if (ev_short[K_SEL] && lst_vld_q[list_idx_q]) begin
            picked_q <= 1'b1;
            pick_idx_q <= list_idx_q;
          end else if (ev_press[K_UP]) begin
            seen_q <= 1'b1;
            list_idx_q <= (list_idx_q == LIST_LAST) ? 5'h00
                                                   : list_idx_q + 5'h01;
          end else if (ev_press[K_DOWN]) begin
            seen_q <= 1'b1;
            list_idx_q <= (list_idx_q == 5'h00) ? LIST_LAST
                                               : list_idx_q - 5'h01;
          end
        end
        ST_LINK: begin
          if (msg_done)
            state_q <= ST_SETUP;
        end
        ST_SET: begin
        end
        default: state_q <= ST_HOME;
      endcase
    end
  end

  // Channel links and delivery
  always_comb begin
    rx_hit = 1'b0;
    hit_ch = '0;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (link_vld_q[c] && link_id_q[c] == rx.id) begin
        rx_hit = 1'b1;
        hit_ch = 4'(c);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int c = 0; c < NCH; c++) begin
        link_vld_q[c] <= 1'b0;
        link_id_q[c] <= '0;
      end
    end else if (link_we) begin
      link_vld_q[ch_q] <= 1'b1;
      link_id_q[ch_q] <= lst_id_q[pick_idx_q];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      dlv <= '0;
    else begin
      dlv.valid <= rx.valid && rx_hit;
      dlv.ch <= hit_ch;
      dlv.value <= rx.value;
    end
  end

  // Pending list, newest at entry 0
  always_comb begin
    lst_hit = 1'b0;
    lst_free = 1'b0;
    hit_idx = '0;
    free_idx = '0;
    for (int i = NLIST - 1; i >= 0; i--) begin
      if (lst_vld_q[i] && lst_id_q[i] == rx.id) begin
        lst_hit = 1'b1;
        hit_idx = 5'(i);
      end
      if (!lst_vld_q[i]) begin
        lst_free = 1'b1;
        free_idx = 5'(i);
      end
    end
    lst_k = lst_hit ? hit_idx : (lst_free ? free_idx : LIST_LAST);
  end

  for (genvar i = 0; i < NLIST; i++) begin : g_list
    logic ins;
    assign ins = rx.valid && !rx_hit && !frozen;
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        lst_vld_q[i] <= 1'b0;
        lst_id_q[i] <= '0;
        lst_age_q[i] <= '0;
      end else if (link_we && pick_idx_q == 5'(i)) begin
        lst_vld_q[i] <= 1'b0;
      end else if (ins && i == 0) begin
        lst_vld_q[i] <= 1'b1;
        lst_id_q[i] <= rx.id;
        lst_age_q[i] <= '0;
      end else if (ins && 5'(i) <= lst_k) begin
        lst_vld_q[i] <= lst_vld_q[(i == 0) ? 0 : i - 1];
        lst_id_q[i] <= lst_id_q[(i == 0) ? 0 : i - 1];
        lst_age_q[i] <= lst_age_q[(i == 0) ? 0 : i - 1];
      end else if (sec && !frozen && lst_vld_q[i]) begin
        lst_age_q[i] <= lst_age_q[i] + 10'h001;
        if (lst_age_q[i] == AGE_SEC - 10'h001)
          lst_vld_q[i] <= 1'b0;
      end
    end
  end

  // Display
  assign disp_state = state_q;
  assign disp_code = digits_q;
  assign disp_cursor = cursor_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      disp_cursor_flash <= 1'b0;
      disp_ch <= '0;
      disp_id <= '0;
      disp_id_flash <= 1'b0;
    end else begin
      disp_cursor_flash <= state_q == ST_CODE && editing_q;
      disp_ch <= (state_q == ST_HOME) ? home_ch_q : ch_q;
      disp_id_flash <= state_q == ST_LIST;
      if (state_q == ST_HOME)
        disp_id <= link_id_q[home_ch_q];
      else if (state_q == ST_LIST && picked_q)
        disp_id <= lst_id_q[pick_idx_q];
      else if (state_q == ST_LIST && seen_q)
        disp_id <= lst_vld_q[list_idx_q] ? lst_id_q[list_idx_q] : '0;
      else
        disp_id <= link_id_q[ch_q];
    end
  end

  // APB registers
  logic [31:0] rdata_d;
  logic unmapped;
  always_comb begin
    rdata_d = '0;
    unmapped = 1'b0;
    case (paddr)
      REG_CTRL: rdata_d[CTRL_DIGIT_BIT] = digit_mode_q;
      REG_CODE_IN: rdata_d[CODE_W-1:0] = code_in_q;
      REG_CODE_SET: rdata_d[CODE_W-1:0] = code_set_q;
      REG_STATUS: begin
        rdata_d[2:0] = state_q;
        rdata_d[ST_LVL_BIT] = lvl_q;
        rdata_d[ST_EDIT_BIT] = editing_q;
      end
      REG_CH_SEL: rdata_d[3:0] = ch_sel_q;
      REG_CH_ID: begin
        rdata_d[ID_W-1:0] = link_id_q[ch_sel_q];
        rdata_d[CHID_VLD_BIT] = link_vld_q[ch_sel_q];
      end
      default: unmapped = 1'b1;
    endcase
  end

  assign pready = 1'b1;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr <= unmapped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      digit_mode_q <= CTRL_RST;
      code_in_q <= CODE_RST;
      code_set_q <= CODE_RST;
      ch_sel_q <= '0;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        REG_CTRL: digit_mode_q <= pwdata[CTRL_DIGIT_BIT];
        REG_CODE_IN: code_in_q <= pwdata[CODE_W-1:0];
        REG_CODE_SET: code_set_q <= pwdata[CODE_W-1:0];
        REG_CH_SEL: ch_sel_q <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_home_edit_long;
    state_q == ST_HOME && ev_long[K_EDIT];
  endsequence
  sequence s_msg_end(acl_state_t st);
    state_q == st && msg_done && !ev_long[K_EXIT] && !idle_to;
  endsequence

  chk_code_prompt: assert property (
    s_home_edit_long and code_in_q != CODE_RST |=> state_q == ST_CODE)
    else $error("code prompt missing");
  chk_no_code_entry: assert property (
    s_home_edit_long and code_in_q == CODE_RST |=> state_q == ST_SETUP)
    else $error("zero code still prompts");
  chk_ok_enter: assert property (
    s_msg_end(ST_OK) |=> state_q == (lvl_q ? ST_SET : ST_SETUP))
    else $error("accepted code not entering level");
  chk_err_home: assert property (
    s_msg_end(ST_ERR) |=> state_q == ST_HOME)
    else $error("bad code not returning home");
  chk_edit_start: assert property (
    state_q == ST_CODE && digit_mode_q && !editing_q && ev_short[K_EDIT]
    && !ev_long[K_EXIT] && !idle_to && !ev_short[K_SEL]
    |=> editing_q && cursor_q == 2'h0 ##1 disp_cursor_flash)
    else $error("edit not at rightmost digit");
  chk_cursor_left: assert property (
    state_q == ST_CODE && editing_q && ev_short[K_EDIT]
    && cursor_q != CUR_LAST && !ev_long[K_EXIT] && !idle_to
    && !ev_short[K_SEL] && !ev_long[K_SEL]
    |=> cursor_q == $past(cursor_q) + 2'h1)
    else $error("cursor did not move left");
  chk_sel_stop: assert property (
    state_q == ST_CODE && ev_short[K_SEL] |=> !editing_q)
    else $error("short select left editing on");
  chk_exit_home: assert property (
    state_q != ST_HOME && (ev_long[K_EXIT] || idle_to)
    |=> state_q == ST_HOME && $stable(home_ch_q))
    else $error("exit or timeout not home");
  chk_first_deliver: assert property (
    rx.valid && rx_hit |=> dlv.valid && dlv.ch == $past(hit_ch))
    else $error("telegram not delivered");
  chk_link_msg: assert property (
    link_we && !ev_long[K_EXIT] && !idle_to
    |=> state_q == ST_LINK ##1 !disp_id_flash)
    else $error("link message missing");
endmodule

// ---- verification/acl_operator_model.sv ----
`timescale 1ns/1ps
module acl_operator_model
  import acl_pkg::*;
#(
  parameter int unsigned TICK_CYC = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Request from bench
  input wire logic req,
  input wire acl_keys_t key_sel,
  input wire logic lng,
  // Front keys and handshake
  output acl_keys_t keys,
  output logic done
);
  int hold;

  // Long press holds just past the threshold, short well below it
  initial begin
    keys = '0;
    done = 1'b0;
    forever begin
      @(posedge clk iff (req && nrst));
      if (lng) begin
        hold = (int'(HOLD_TK) + 10) * TICK_CYC;
      end else begin
        hold = 40 * TICK_CYC;
      end
      keys <= key_sel;
      repeat (hold) @(posedge clk);
      keys <= '0;
      repeat (20 * TICK_CYC) @(posedge clk);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
    end
  end
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import acl_pkg::*;
;
  localparam int TK = 4;
  localparam acl_keys_t KUP = 5'h10;
  localparam acl_keys_t KDN = 5'h08;
  localparam acl_keys_t KED = 5'h04;
  localparam acl_keys_t KSL = 5'h02;
  localparam acl_keys_t KEX = 5'h01;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  acl_keys_t keys;
  acl_tgm_t rx = '0;
  acl_dlv_t dlv;
  acl_state_t disp_state;
  logic [15:0] disp_code;
  logic [1:0] disp_cursor;
  logic disp_cursor_flash;
  logic [3:0] disp_ch;
  logic [ID_W-1:0] disp_id;
  logic disp_id_flash;
  logic op_req = 1'b0;
  acl_keys_t op_key = '0;
  logic op_lng = 1'b0;
  logic op_done;
  int error_cnt = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  acl_core #(.TICK_CYC(TK)) acl_core_inst (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .keys(keys), .rx(rx), .dlv(dlv),
    .disp_state(disp_state), .disp_code(disp_code),
    .disp_cursor(disp_cursor), .disp_cursor_flash(disp_cursor_flash),
    .disp_ch(disp_ch), .disp_id(disp_id), .disp_id_flash(disp_id_flash)
  );

  acl_operator_model #(.TICK_CYC(TK)) acl_operator_model_inst (
    .clk(clk), .nrst(nrst), .req(op_req), .key_sel(op_key),
    .lng(op_lng), .keys(keys), .done(op_done)
  );

  task automatic end_of_test();
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    error_cnt++;
    $display("timeout at %0t", $time);
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_st(input acl_state_t exp);
    chk(32'(disp_state), 32'(exp));
  endtask

  task automatic wait_st(input acl_state_t s, input int lim);
    int n;
    n = 0;
    while (disp_state !== s && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) timed_out();
    chk_st(s);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic eerr);
    logic [31:0] got;
    logic err;
    apb(1'b0, a, 32'h0000_0000, got, err);
    chk(got, exp);
    chk(32'(err), 32'(eerr));
  endtask

  task automatic press(input acl_keys_t k, input logic lng);
    int n;
    @(posedge clk);
    op_key <= k;
    op_lng <= lng;
    op_req <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (op_done !== 1'b1 && n < 20000);
    if (n >= 20000) timed_out();
    op_req <= 1'b0;
  endtask

  task automatic tgm(input logic [16:0] id, input logic ev,
                     input logic [3:0] ch);
    @(posedge clk);
    rx <= '{valid: 1'b1, id: id, value: 16'h1234};
    @(posedge clk);
    rx.valid <= 1'b0;
    #1;
    chk(32'(dlv.valid), 32'(ev));
    if (ev) begin
      chk(32'(dlv.ch), 32'(ch));
      chk(32'(dlv.value), 32'h0000_1234);
    end
  endtask

  task automatic t_reset();
    chk_st(ST_HOME);
    rd(REG_CODE_IN, 32'h0000_0000, 1'b0);
    rd(REG_CODE_SET, 32'h0000_0000, 1'b0);
    rd(REG_STATUS, 32'h0000_0000, 1'b0);
    rd(8'h40, 32'h0000_0000, 1'b1);
    $display("test reset done");
  endtask

  task automatic t_link();
    press(KED, 1'b1);
    wait_st(ST_SETUP, 1000);
    tgm(17'h0_1111, 1'b0, 4'h0);
    tgm(17'h0_2222, 1'b0, 4'h0);
    press(KUP, 1'b0);
    chk(32'(disp_ch), 32'h0000_0001);
    press(KSL, 1'b0);
    chk_st(ST_LIST);
    chk(32'(disp_id_flash), 32'h0000_0001);
    press(KSL, 1'b0);
    chk(32'(disp_id), 32'h0000_2222);
    press(KSL, 1'b1);
    chk_st(ST_LINK);
    chk(32'(disp_id_flash), 32'h0000_0000);
    wait_st(ST_SETUP, 250 * TK);
    wr(REG_CH_SEL, 32'h0000_0001);
    rd(REG_CH_ID, 32'h0002_2222, 1'b0);
    tgm(17'h0_2222, 1'b1, 4'h1);
    tgm(17'h0_1111, 1'b0, 4'h0);
    press(KSL, 1'b0);
    tgm(17'h0_3333, 1'b0, 4'h0);
    press(KSL, 1'b0);
    chk(32'(disp_id), 32'h0000_1111);
    press(KEX, 1'b1);
    chk_st(ST_HOME);
    chk(32'(disp_ch), 32'h0000_0000);
    $display("test link done");
  endtask

  task automatic t_direct();
    wr(REG_CODE_IN, 32'h0000_0003);
    press(KED, 1'b1);
    chk_st(ST_CODE);
    repeat (3) press(KUP, 1'b0);
    chk(32'(disp_code), 32'h0000_0003);
    press(KSL, 1'b1);
    chk_st(ST_OK);
    repeat (150 * TK) @(posedge clk);
    chk_st(ST_OK);
    wait_st(ST_SETUP, 100 * TK);
    press(KEX, 1'b1);
    chk_st(ST_HOME);
    $display("test direct done");
  endtask

  task automatic t_wrong();
    wr(REG_CODE_SET, 32'h0000_0002);
    press(KSL, 1'b1);
    chk_st(ST_CODE);
    press(KDN, 1'b0);
    chk(32'(disp_code), 32'h0000_9999);
    press(KSL, 1'b1);
    chk_st(ST_ERR);
    wait_st(ST_HOME, 250 * TK);
    $display("test wrong done");
  endtask

  task automatic t_digit();
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_CODE_IN, 32'h0000_002a);
    press(KED, 1'b1);
    chk_st(ST_CODE);
    press(KED, 1'b0);
    chk(32'(disp_cursor), 32'h0000_0000);
    chk(32'(disp_cursor_flash), 32'h0000_0001);
    repeat (2) press(KUP, 1'b0);
    chk(32'(disp_code), 32'h0000_0002);
    press(KED, 1'b0);
    chk(32'(disp_cursor), 32'h0000_0001);
    repeat (4) press(KUP, 1'b0);
    chk(32'(disp_code), 32'h0000_0042);
    press(KSL, 1'b0);
    chk(32'(disp_cursor_flash), 32'h0000_0000);
    press(KSL, 1'b1);
    chk_st(ST_OK);
    wait_st(ST_SETUP, 250 * TK);
    $display("test digit done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_link();
    t_direct();
    t_wrong();
    t_digit();
    end_of_test();
  end
endmodule
